// ---- src/clhp_pkg.sv ----
// Constants and types of the character display host port.
// Assumes one 200 MHz clock and a synchronous reset.
package clhp_pkg;
    localparam int CLK_NS   = 5;   // Clock period
    localparam int BUSY_NS  = 37;  // Internal operation time
    localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCAN_DIV = 4;   // Cycles per shift clock phase
    localparam int CRAM_N   = 80;  // Character RAM entries
    localparam int GRAM_N   = 64;  // Glyph RAM entries
    localparam int DOTS     = 5;   // Dots per glyph row
    localparam int VIS      = 8;   // Positions driven per line
    localparam int COM_N    = 16;  // Common lines
    localparam logic [6:0] LINE_N  = 7'h28;
    localparam logic [6:0] L1_END  = 7'h27;
    localparam logic [6:0] L2_BEG  = 7'h40;
    localparam logic [6:0] L2_END  = 7'h67;
    localparam logic [6:0] ONE_END = 7'h4f;
    localparam logic [6:0] ONE_N   = 7'h50;
    localparam logic [4:0] DUTY8   = 5'h08;
    localparam logic [4:0] DUTY11  = 5'h0b;
    localparam logic [4:0] DUTY16  = 5'h10;
    // Instruction field positions
    localparam int I_CADR  = 7;    // 1aaaaaaa char address
    localparam int I_GADR  = 6;    // 01aaaaaa glyph address
    localparam int I_FUNC  = 5;    // 001 wide lines font
    localparam int I_SHIFT = 4;    // 0001 display right
    localparam int I_ENTRY = 2;    // 000001 inc
    localparam int F_WIDE  = 4;
    localparam int F_LINES = 3;
    localparam int F_FONT  = 2;
    localparam int F_DISP  = 3;
    localparam int F_RIGHT = 2;
    localparam int F_INC   = 1;
    // Reset values of the configuration
    localparam logic RST_WIDE  = 1'b1;
    localparam logic RST_LINES = 1'b0;
    localparam logic RST_FONT  = 1'b0;
    localparam logic RST_INC   = 1'b1;
    localparam logic [7:0] ROM10_BEG = 8'he0; // Tall glyph codes
    localparam logic [3:0] GLYPH_HI  = 4'h0;  // Codes using glyph RAM
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_WAIT  = 2'b10
    } clhp_state_t;
    typedef struct packed {
        logic       rs;
        logic       rw;
        logic [7:0] data;
    } clhp_bus_t;
endpackage

// ---- src/clhp_port.sv ----
// Host port, character/glyph RAM and expander scan.
// Assumes the host pins are asynchronous to ref_clk.
`timescale 1ns/10ps

// Write-data queue between host and RAM engine
module clhp_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];     // Storage
    logic [AW-1:0] wp_q;         // Write index
    logic [AW-1:0] rp_q;         // Read index
    logic [AW:0]   cnt_q;        // Fill level
    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;
    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];

    // Pointers wrap at the depth
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                mem_q[wp_q] <= in_data;
                wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // clhp_fifo

module clhp_port #(
    parameter int FIFO_D = 16
) (
    input  wire logic  ref_clk,
    input  wire logic  sys_rst,
    input  wire logic  bus_strobe,
    input  wire logic  register_select,
    input  wire logic  read_write_select,
    input  wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic [7:0] host_data_oe,
    output logic       internal_busy_flag,
    output logic       expander_serial_pixels,
    output logic       expander_shift_clock,
    output logic       expander_latch_clock,
    output logic       drive_polarity_toggle,
    output logic [clhp_pkg::COM_N-1:0] common_drive_lines
);
    import clhp_pkg::*;

    // Pin synchronisers; stage one only feeds stage two
    clhp_bus_t b1_q, b2_q;
    logic e1_q, e2_q, e3_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            b1_q <= '0;
            b2_q <= '0;
            e1_q <= 1'b0;
            e2_q <= 1'b0;
            e3_q <= 1'b0;
        end else begin
            b1_q <= '{register_select, read_write_select,
                      host_data_in};
            b2_q <= b1_q;
            e1_q <= bus_strobe;
            e2_q <= e1_q;
            e3_q <= e2_q;
        end
    end

    // Block state
    clhp_state_t st_q;
    logic [3:0] cnt_q;           // Wait counter
    logic [6:0] ptr_q;           // address_pointer
    logic       tgt_q;           // 1: glyph RAM selected
    logic [7:0] dr_q;            // data_register
    logic       wide_q;          // 8-line bus
    logic       two_q;           // line_count_select
    logic       font_q;          // Tall glyphs
    logic       inc_q;           // Step direction
    logic [6:0] off_q;           // Display shift offset
    logic       nib_q;           // Second nibble due
    logic [3:0] hi_q;            // Held upper nibble
    logic [7:0] cram_q [CRAM_N]; // display_char_ram
    logic [7:0] gram_q [GRAM_N]; // glyph_ram

    // Transfer completes on strobe fall; narrow bus needs two
    wire fall = e3_q & ~e2_q;
    wire done = fall & (wide_q | nib_q);
    wire [7:0] byte_in = wide_q ? b2_q.data
                                : {hi_q, b2_q.data[7:4]};
    wire idle = (st_q == ST_IDLE);
    wire fifo_ov;
    wire [7:0] fifo_od;
    wire fifo_ir;
    wire busy_w = ~idle | fifo_ov;
    wire wr_ir = done & ~b2_q.rs & ~b2_q.rw & ~busy_w;
    wire wr_dr = done & b2_q.rs & ~b2_q.rw;
    wire rd_dr = done & b2_q.rs & b2_q.rw & idle;
    wire pop   = idle & fifo_ov;
    wire [7:0] ir = byte_in;

    // Character index: second line sits after the first
    wire cval = two_q ? (ptr_q[5:0] < LINE_N[5:0])
                      : (ptr_q < ONE_N);
    wire [6:0] cidx = (two_q & ptr_q[6])
                    ? 7'(ptr_q[5:0]) + LINE_N : ptr_q;
    wire [7:0] ram_rd = tgt_q ? gram_q[ptr_q[5:0]]
                      : (cval ? cram_q[cidx] : 8'h00);
    wire [6:0] span = two_q ? LINE_N : ONE_N;

    // Pointer step with per-mode wrap
    function automatic logic [6:0] step(input logic [6:0] a,
            input logic inc, input logic two, input logic g);
        logic [6:0] r;
        r = inc ? a + 7'h01 : a - 7'h01;
        if (g) begin
            r = {1'b0, r[5:0]};
        end else if (two) begin
            if (inc && a == L1_END) r = L2_BEG;
            else if (inc && a == L2_END) r = 7'h00;
            else if (!inc && a == 7'h00) r = L2_END;
            else if (!inc && a == L2_BEG) r = L1_END;
        end else begin
            if (inc && a == ONE_END) r = 7'h00;
            else if (!inc && a == 7'h00) r = ONE_END;
        end
        return r;
    endfunction
    wire [6:0] ptr_nx = step(ptr_q, inc_q, two_q, tgt_q);

    // Written bytes queue here; busy stays up while any wait
    clhp_fifo #(.W(8), .D(FIFO_D)) u_fifo (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_valid  (wr_dr),
        .in_ready  (fifo_ir),
        .in_data   (byte_in),
        .out_valid (fifo_ov),
        .out_ready (idle),
        .out_data  (fifo_od)
    );

    // Nibble pairing, upper half first
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            nib_q <= 1'b0;
            hi_q  <= 4'h0;
        end else if (fall & ~wide_q) begin
            nib_q <= ~nib_q;
            hi_q  <= b2_q.data[7:4];
        end else if (wide_q) begin
            nib_q <= 1'b0;
        end
    end

    // Instruction decode and RAM engine
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_q   <= ST_IDLE;
            cnt_q  <= 4'h0;
            ptr_q  <= 7'h00;
            tgt_q  <= 1'b0;
            dr_q   <= 8'h00;
            wide_q <= RST_WIDE;
            two_q  <= RST_LINES;
            font_q <= RST_FONT;
            inc_q  <= RST_INC;
            off_q  <= 7'h00;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    cnt_q <= 4'h0;
                    if (wr_ir) begin
                        st_q <= ST_WAIT;
                        if (ir[I_CADR]) begin
                            ptr_q <= ir[6:0];
                            tgt_q <= 1'b0;
                            st_q  <= ST_FETCH;
                        end else if (ir[I_GADR]) begin
                            ptr_q <= {1'b0, ir[5:0]};
                            tgt_q <= 1'b1;
                            st_q  <= ST_FETCH;
                        end else if (ir[I_FUNC]) begin
                            wide_q <= ir[F_WIDE];
                            two_q  <= ir[F_LINES];
                            font_q <= ir[F_FONT];
                            off_q  <= 7'h00;
                        end else if (ir[I_SHIFT] & ir[F_DISP]) begin
                            // Offset wraps inside the line span
                            if (ir[F_RIGHT])
                                off_q <= (off_q == 7'h00)
                                       ? span - 7'h01 : off_q - 7'h01;
                            else
                                off_q <= (off_q == span - 7'h01)
                                       ? 7'h00 : off_q + 7'h01;
                        end else if (ir[I_ENTRY]) begin
                            inc_q <= ir[F_INC];
                        end
                    end else if (pop) begin
                        ptr_q <= ptr_nx;
                        st_q  <= ST_WAIT;
                    end else if (rd_dr) begin
                        ptr_q <= ptr_nx;
                        st_q  <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    dr_q <= ram_rd;
                    st_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == 4'(BUSY_CYC - 1)) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // RAM writes; out-of-range char addresses are dropped
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < CRAM_N; i++) cram_q[i] <= 8'h00;
            for (int i = 0; i < GRAM_N; i++) gram_q[i] <= 8'h00;
        end else if (pop & ~tgt_q & cval) begin
            cram_q[cidx] <= fifo_od;
        end else if (pop & tgt_q) begin
            gram_q[ptr_q[5:0]] <= fifo_od;
        end
    end

    // Read drive; instruction register has no read path
    wire drive = e2_q & b2_q.rw;
    wire [7:0] rd_val = b2_q.rs ? dr_q
                      : {busy_w, ptr_q};
    wire [7:0] rd_lane = wide_q ? rd_val
                       : (nib_q ? {rd_val[3:0], 4'h0}
                                : {rd_val[7:4], 4'h0});
    wire [7:0] oe_mask = wide_q ? 8'hff : 8'hf0;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            host_data_out      <= 8'h00;
            host_data_oe       <= 8'h00;
            internal_busy_flag <= 1'b0;
        end else begin
            host_data_out      <= drive ? rd_lane : 8'h00;
            host_data_oe       <= drive ? oe_mask : 8'h00;
            internal_busy_flag <= busy_w;
        end
    end

    // Scan counters and duty
    logic [1:0] div_q;
    logic [2:0] col_q;
    logic [2:0] pos_q;
    logic [3:0] row_q;
    wire [4:0] duty = two_q ? DUTY16 : (font_q ? DUTY11 : DUTY8);
    wire line = two_q & row_q[3];
    wire [3:0] drow = two_q ? {1'b0, row_q[2:0]} : row_q;
    wire [6:0] sum = 7'(pos_q) + off_q;
    wire [6:0] wrap = (sum >= span) ? sum - span : sum;
    wire [6:0] sidx = line ? wrap + LINE_N : wrap;
    wire [7:0] code = cram_q[sidx];

    // Tall ROM codes use ten rows, the rest eight
    wire tall = (code >= ROM10_BEG);
    wire [4:0] rom_pat = (tall ? (drow < 4'ha) : (drow < 4'h8))
                       ? (code[4:0] ^ {1'b0, drow}) : 5'h00;
    wire [4:0] ram_pat = font_q
                       ? gram_q[{code[2:1], drow}][4:0]
                       : gram_q[{code[2:0], drow[2:0]}][4:0];
    wire [4:0] pat = (code[7:4] == GLYPH_HI) ? ram_pat : rom_pat;
    wire pix = pat[3'(DOTS - 1) - col_q];
    wire tick = (div_q == 2'(SCAN_DIV - 1));
    wire last_dot = (col_q == 3'(DOTS - 1))
                  & (pos_q == 3'(VIS - 1));
    logic pix_q, sck_q, lat_q, pol_q;

    // Shift on clock rise, latch once per row
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div_q <= 2'h0;
            col_q <= 3'h0;
            pos_q <= 3'h0;
            row_q <= 4'h0;
            pix_q <= 1'b0;
            sck_q <= 1'b0;
            lat_q <= 1'b0;
            pol_q <= 1'b0;
        end else begin
            div_q <= tick ? 2'h0 : div_q + 2'h1;
            if (tick & ~sck_q) begin
                pix_q <= pix;
                sck_q <= 1'b1;
                lat_q <= 1'b0;
            end else if (tick) begin
                sck_q <= 1'b0;
                col_q <= (col_q == 3'(DOTS - 1)) ? 3'h0 : col_q + 3'h1;
                if (col_q == 3'(DOTS - 1)) pos_q <= pos_q + 3'h1;
                if (last_dot) begin
                    lat_q <= 1'b1;
                    if (5'(row_q) + 5'h01 >= duty) begin
                        row_q <= 4'h0;
                        pol_q <= ~pol_q;
                    end else begin
                        row_q <= row_q + 4'h1;
                    end
                end
            end
        end
    end
    assign expander_serial_pixels = pix_q;
    assign expander_shift_clock   = sck_q;
    assign expander_latch_clock   = lat_q;
    assign drive_polarity_toggle  = pol_q;

    // One common selected per row; lines past duty idle
    logic [COM_N-1:0] com_q;
    generate
        for (genvar g = 0; g < COM_N; g++) begin : g_com
            always_ff @(posedge ref_clk) begin
                if (sys_rst) com_q[g] <= 1'b0;
                else com_q[g] <= (row_q == 4'(g))
                              && (5'(g) < duty);
            end
        end
    endgenerate
    assign common_drive_lines = com_q;

    // Checks
    property p_busy_blocks;
        @(posedge ref_clk) disable iff (sys_rst)
        (done && !b2_q.rs && !b2_q.rw && st_q == ST_WAIT
         && !fifo_ov) |=> $stable(ptr_q) && $stable(tgt_q);
    endproperty
    a_busy_blocks: assert property (p_busy_blocks)
        else $error("instruction taken while busy");

    property p_status;
        @(posedge ref_clk) disable iff (sys_rst)
        (drive && !b2_q.rs && wide_q) |=>
        host_data_out == {$past(busy_w), $past(ptr_q)};
    endproperty
    a_status: assert property (p_status)
        else $error("status read value wrong");

    property p_narrow_oe;
        @(posedge ref_clk) disable iff (sys_rst)
        (host_data_oe != 8'h00 && !$past(wide_q))
        |-> host_data_oe == 8'hf0;
    endproperty
    a_narrow_oe: assert property (p_narrow_oe)
        else $error("narrow bus drove lower lines");

    sequence s_fetch_done;
        st_q == ST_FETCH ##1 (st_q == ST_WAIT && dr_q == $past(ram_rd));
    endsequence
    property p_addr_load;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_ir && ir[I_CADR]) |=>
        (ptr_q == $past(ir[6:0]) && !tgt_q) ##0 s_fetch_done;
    endproperty
    a_addr_load: assert property (p_addr_load)
        else $error("address load or fetch wrong");

    property p_prefetch;
        @(posedge ref_clk) disable iff (sys_rst)
        (rd_dr && !wr_ir && !pop) |=> s_fetch_done;
    endproperty
    a_prefetch: assert property (p_prefetch)
        else $error("no prefetch after data read");

    property p_line_wrap;
        @(posedge ref_clk) disable iff (sys_rst)
        (pop && inc_q && two_q && !tgt_q && ptr_q == L1_END)
        |=> ptr_q == L2_BEG;
    endproperty
    a_line_wrap: assert property (p_line_wrap)
        else $error("pointer did not jump to line two");

    property p_store;
        @(posedge ref_clk) disable iff (sys_rst)
        (pop && !tgt_q && cval) |=> cram_q[$past(cidx)] == $past(fifo_od);
    endproperty
    a_store: assert property (p_store)
        else $error("queued byte not stored");

    property p_busy_len;
        @(posedge ref_clk) disable iff (sys_rst)
        (st_q == ST_FETCH) |=> (st_q == ST_WAIT)[*8] ##1 idle;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy time wrong");

    property p_shift_right;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_ir && ir[7:4] == 4'h1 && ir[F_DISP] && ir[F_RIGHT]
         && two_q && off_q == 7'h00) |=> off_q == 7'h27;
    endproperty
    a_shift_right: assert property (p_shift_right)
        else $error("right shift did not wrap");

    property p_com_idle;
        @(posedge ref_clk) disable iff (sys_rst)
        (!$past(two_q) && !$past(font_q) && !$past(sys_rst))
        |-> common_drive_lines[15:8] == 8'h00;
    endproperty
    a_com_idle: assert property (p_com_idle)
        else $error("unused common line selected");
endmodule // clhp_port

// ---- verif/clhp_host.sv ----
// Bus master model of the host processor on the display port.
// Assumes the bench resolves the shared data wire from the port's enables alone.
`timescale 1ns/10ps
module clhp_host (
    input  wire logic       ref_clk,
    input  wire logic [3:0] hold,
    output logic            bus_strobe,
    output logic            register_select,
    output logic            read_write_select,
    output logic [7:0]      host_drive,
    input  wire logic [7:0] host_data_out,
    input  wire logic [7:0] host_data_oe
);
    // Idle pins at time zero
    initial begin
        bus_strobe = 1'b0;
        register_select = 1'b0;
        read_write_select = 1'b0;
        host_drive = 8'h5a;
    end

    // One strobe; selects settle first and are held past the fall
    // Strobe stays high for hold cycles; reads need 3 for the answer
    task automatic beat(input logic s, input logic w, input logic [7:0] d,
                        output logic [7:0] r, output logic [7:0] o);
        @(negedge ref_clk);
        register_select = s;
        read_write_select = w;
        host_drive = w ? ~host_drive : d; // Released bus never shows stale data
        @(negedge ref_clk);
        bus_strobe = 1'b1;
        repeat (hold) @(negedge ref_clk);
        r = host_data_out;
        o = host_data_oe;
        bus_strobe = 1'b0;
        repeat (4) @(negedge ref_clk);
        host_drive = ~host_drive;
    endtask

    // Byte transfer; narrow bus sends upper nibble first
    task automatic xfer(input logic s, input logic w, input logic nar,
                        input logic [7:0] d, output logic [7:0] r, output logic [7:0] o);
        logic [7:0] r1;
        logic [7:0] o2;
        if (nar) begin
            beat(s, w, {d[7:4], ~host_drive[3:0]}, r1, o);
            beat(s, w, {d[3:0], ~host_drive[3:0]}, r, o2);
            r = {r1[7:4], r[7:4]};
        end else begin
            beat(s, w, d, r, o);
        end
    endtask
endmodule // clhp_host

// ---- verif/char_lcd_host_port_ram_access_test.sv ----
// Self-checking bench of the character display host port.
// Assumes clhp_host as master and a reference model kept here.
`timescale 1ns/10ps
module char_lcd_host_port_ram_access_test;
    import clhp_pkg::*;
    logic        ref_clk = 1'b0;  // 200 MHz
    logic        sys_rst = 1'b1;
    logic        stb, rs, rw, busy;
    logic [7:0]  hdrv, dout, oe, bus_w;
    logic [15:0] cdl;             // Common lines
    logic        pix, sck, lat, pol;  // Expander pins
    logic        sck_p = 1'b0, lat_p = 1'b0, pol_p = 1'b0;
    logic [3:0]  hold = 4'h6;     // Strobe high time
    int          nsck = 0;        // Shift rises in this row
    int          err_count = 0, cmp_count = 0;
    int          mem [256];       // Model RAM, glyph at 128 up
    logic [6:0]  ptr = 7'h00;
    logic [7:0]  dr = 8'h00;
    logic        g = 1'b0, inc = 1'b1, two = 1'b0, nar = 1'b0;

    always #2.5 ref_clk = ~ref_clk;
    assign bus_w = (dout & oe) | (hdrv & ~oe); // Wire level from enables

    clhp_host host_i (.ref_clk(ref_clk), .hold(hold), .bus_strobe(stb), .register_select(rs),
        .read_write_select(rw), .host_drive(hdrv), .host_data_out(dout), .host_data_oe(oe));
    clhp_port clhp_port_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_strobe(stb),
        .register_select(rs), .read_write_select(rw), .host_data_in(bus_w),
        .host_data_out(dout), .host_data_oe(oe), .internal_busy_flag(busy),
        .expander_serial_pixels(pix), .expander_shift_clock(sck), .expander_latch_clock(lat),
        .drive_polarity_toggle(pol), .common_drive_lines(cdl));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Each latch ends one row of dots; polarity turns only at a latch
    always @(negedge ref_clk) begin
        if (!sys_rst) begin
            if (sck & !sck_p) nsck++;
            if (lat & !lat_p) begin
                chk(8'(nsck), 8'(VIS * DOTS));
                nsck = 0;
            end
            if (pol != pol_p) chk({7'h00, lat & !lat_p}, 8'h01);
            sck_p = sck;
            lat_p = lat;
            pol_p = pol;
        end
    end

    // Address lies in a stored area of the current mode
    function automatic logic ok(input logic [6:0] a);
        return g | (two ? (a <= 7'h27 || (a >= 7'h40 && a <= 7'h67)) : a <= 7'h4f);
    endfunction

    // Pointer moves by one; character lines wrap at their own ends
    task automatic step();
        ptr = inc ? ptr + 7'h01 : ptr - 7'h01;
        if (g) ptr[6] = 1'b0; // Glyph pointer is six bits
        else if (two && inc && ptr == 7'h28) ptr = 7'h40;
        else if (two && inc && ptr == 7'h68) ptr = 7'h00;
        else if (two && !inc && ptr == 7'h3f) ptr = 7'h27;
        else if (!inc && ptr == 7'h7f) ptr = two ? 7'h67 : 7'h4f;
        else if (!two && inc && ptr == 7'h50) ptr = 7'h00;
    endtask

    task automatic op(input logic s, input logic w, input logic [7:0] d,
                      output logic [7:0] r);
        logic [7:0] o;
        host_i.xfer(s, w, nar, d, r, o);
        if (w) chk(o, nar ? 8'hf0 : 8'hff);
    endtask

    // Poll until free, then check the whole status byte
    task automatic idle();
        logic [7:0] r;
        r = 8'h80;
        for (int i = 0; i < 30 && r[7] !== 1'b0; i++) op(1'b0, 1'b1, 8'h00, r);
        chk(r, {1'b0, ptr});
        if (!two) chk(cdl[15:8], 8'h00);
    endtask

    task automatic instr(input logic [7:0] d);
        logic [7:0] r;
        op(1'b0, 1'b0, d, r);
        if (d[7] | d[6]) begin
            g = !d[7];
            ptr = d[7] ? d[6:0] : {1'b0, d[5:0]};
            dr = ok(ptr) ? 8'(mem[{g, ptr}]) : 8'h00;
        end else if (d[5]) begin
            nar = !d[4];
            two = d[3];
        end else if (d[2] & ~(d[4] & d[3])) begin // Display shift is not entry mode
            inc = d[1];
        end
        idle();
    endtask

    task automatic wr(input logic [7:0] d);
        logic [7:0] r;
        op(1'b1, 1'b0, d, r);
        chk({7'h00, busy}, 8'h01);
        if (ok(ptr)) mem[{g, ptr}] = d;
        step();
    endtask

    task automatic rd();
        logic [7:0] r;
        op(1'b1, 1'b1, 8'h00, r);
        chk(r, dr);
        step();
        dr = ok(ptr) ? 8'(mem[{g, ptr}]) : 8'h00;
        idle();
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog well past the expected run
    initial begin
        #(40000 * 5);
        err_count++;
        wrap_up();
    end

    initial begin
        logic [6:0] a;
        logic [7:0] r;
        void'($urandom(32'h3368));
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'b0;
        idle();
        chk({7'h00, pix}, 8'h00);
        $display("test reset done");
        a = 7'($urandom_range(0, 64));
        instr({1'b1, a});
        repeat (8) wr(8'($urandom));
        idle();
        instr({1'b1, a});
        repeat (8) rd();
        $display("test char ram done");
        instr(8'h04);
        instr(8'h90);
        repeat (3) wr(8'($urandom));
        idle();
        instr(8'h90);
        repeat (3) rd();
        instr(8'h06);
        $display("test decrement done");
        instr(8'h48);
        repeat (4) wr(8'($urandom));
        idle();
        instr(8'h48);
        repeat (4) rd();
        $display("test glyph done");
        instr(8'h38);
        instr(8'h1c);
        instr(8'ha6);
        repeat (3) wr(8'($urandom));
        idle();
        instr(8'ha6);
        repeat (3) rd();
        instr(8'ha8);
        rd();
        $display("test two line done");
        instr(8'h28);
        instr(8'h82);
        wr(8'($urandom));
        idle();
        instr(8'h82);
        rd();
        $display("test narrow done");
        // Writes closer than the busy time queue up; a stray instruction is refused
        instr(8'h30);
        instr(8'h80);
        hold = 4'h2;
        repeat (4) wr(8'($urandom));
        op(1'b0, 1'b0, 8'h8f, r);
        hold = 4'h6;
        idle();
        instr(8'h80);
        repeat (4) rd();
        $display("test queue done");
        wrap_up();
    end
endmodule // char_lcd_host_port_ram_access_test
